/* rtl/sxm_map.vh */
/*
 * Register offsets, field positions, reset values and frame geometry
 * for the transfer, monitor and signaling register group.
 * Assumes a demultiplexed 4-bit register address on the host port.
 */
`ifndef SXM_MAP_VH
`define SXM_MAP_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define SXM_OFF_RX_ADDR_B 4'h6
`define SXM_OFF_TX_ADDR_A 4'h7
`define SXM_OFF_TX_ADDR_B 4'h8
`define SXM_OFF_XFER_CTRL 4'h9
`define SXM_OFF_MON_ADDR 4'ha
`define SXM_OFF_MON_FIFO 4'hb
`define SXM_OFF_SIG_FIFO 4'hc

// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define SXM_BIT_IF_SEL 7
`define SXM_BIT_EN_B 7
`define SXM_BIT_EN_A 6
`define SXM_BIT_SEARCH_ON 6
`define SXM_TYPE_NONE 3'h0
`define SXM_RST_ADDR 8'h00
`define SXM_RST_CTRL 8'h00
`define SXM_RST_ACTIVE_IND 8'h00
`define SXM_EMPTY_READ 8'h00

// ------------------------------------------------------------
// Buffer depths and frame geometry
// ------------------------------------------------------------
`define SXM_MON_DEPTH 16
`define SXM_MON_AW 4
`define SXM_SIG_DEPTH 9
`define SXM_SIG_AW 4
`define SXM_FRAME_CW 10

`endif

/* rtl/sxm_fifo.v */
/*
 * Small first-in first-out store with a synchronous clear.
 * Assumes one clock; the head word is visible while not empty.
 */
`timescale 1ns/1ps
module sxm_fifo #(
    parameter W = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire sys_clk,
    input wire reset,
    input wire clear,
    input wire push,
    input wire [W-1:0] push_data,
    input wire pop,
    output wire [W-1:0] head,
    output wire empty,
    output wire full
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] rd_q;
    reg [AW-1:0] wr_q;
    reg [AW:0] cnt_q;
    wire do_push;
    wire do_pop;

    function [AW-1:0] ptr_next;
        input [AW-1:0] p;
        begin
            if (p == DEPTH - 1)
                ptr_next = {AW{1'b0}};
            else
                ptr_next = p + 1'b1;
        end
    endfunction

    assign empty = (cnt_q == {(AW+1){1'b0}});
    assign full = (cnt_q == DEPTH);
    assign head = mem[rd_q];
    assign do_pop = pop & ~empty;
    // A full store takes a new word only when one leaves in the same cycle.
    assign do_push = push & (~full | do_pop);

    always @(posedge sys_clk) begin
        if (do_push)
            mem[wr_q] <= push_data;
    end

    always @(posedge sys_clk) begin
        if (reset || clear) begin
            rd_q <= {AW{1'b0}};
            wr_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (do_push)
                wr_q <= ptr_next(wr_q);
            if (do_pop)
                rd_q <= ptr_next(rd_q);
            if (do_push && !do_pop)
                cnt_q <= cnt_q + 1'b1;
            else if (do_pop && !do_push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule

/* rtl/sxm_slot_timer.v */
/*
 * Serial frame timer: synchronises the link clock and frame sync,
 * finds link clock edges and counts bits and time slots.
 * Assumes the link clock is at most a quarter of sys_clk.
 */
`timescale 1ns/1ps
`include "sxm_map.vh"
module sxm_slot_timer (
    input wire sys_clk,
    input wire reset,
    input wire link_clk,
    input wire link_fsc,
    output wire rise_tick,
    output wire fall_tick,
    output wire [6:0] slot,
    output wire [2:0] bit_idx
);
    reg clk_m_q;
    reg clk_s_q;
    reg clk_p_q;
    reg fsc_m_q;
    reg fsc_s_q;
    reg [`SXM_FRAME_CW-1:0] cnt_q;

    assign rise_tick = clk_s_q & ~clk_p_q;
    assign fall_tick = ~clk_s_q & clk_p_q;
    assign slot = cnt_q[`SXM_FRAME_CW-1:3];
    assign bit_idx = cnt_q[2:0];

    always @(posedge sys_clk) begin
        if (reset) begin
            clk_m_q <= 1'b0;
            clk_s_q <= 1'b0;
            clk_p_q <= 1'b0;
            fsc_m_q <= 1'b0;
            fsc_s_q <= 1'b0;
        end else begin
            clk_m_q <= link_clk;
            clk_s_q <= clk_m_q;
            clk_p_q <= clk_s_q;
            fsc_m_q <= link_fsc;
            fsc_s_q <= fsc_m_q;
        end
    end

    // Frame sync seen at a rising edge marks the next bit as frame bit 0.
    always @(posedge sys_clk) begin
        if (reset)
            cnt_q <= {`SXM_FRAME_CW{1'b0}};
        else if (rise_tick && fsc_s_q)
            cnt_q <= {`SXM_FRAME_CW{1'b0}};
        else if (rise_tick)
            cnt_q <= cnt_q + 1'b1;
    end
endmodule

/* rtl/sxm_regs.v */
/*
 * Register group for two synchronous transfer channels, the monitor
 * channel handler with its data buffer, and the signaling change queue.
 * Assumes the host port strobes are one sys_clk wide and that the
 * command, data and control memory logic sit outside this block.
 */
`timescale 1ns/1ps
`include "sxm_map.vh"
module sxm_regs (
    input wire sys_clk,
    input wire reset,
    input wire [3:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    output wire [7:0] bus_rdata,
    input wire link_clk,
    input wire link_fsc,
    input wire cfi_din,
    output wire cfi_dout,
    output wire cfi_dout_oe,
    input wire pcm_din,
    output wire pcm_dout,
    output wire pcm_dout_oe,
    input wire [7:0] sync_data_a,
    input wire [7:0] sync_data_b,
    output wire [7:0] sync_rx_b_data,
    output wire sync_rx_b_stb,
    output wire mem_access_busy,
    input wire search_cmd,
    output wire active_found,
    input wire mon_tx_en,
    input wire mon_rx_en,
    input wire mon_fifo_reset,
    output wire mon_fifo_empty,
    output wire mon_fifo_full,
    output wire [1:0] mon_xfer_ctrl,
    input wire sig_change_stb,
    input wire [6:0] sig_change_addr,
    input wire sig_fifo_reset,
    output wire sig_fifo_empty
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam [7:0] ind_rst = `SXM_RST_ACTIVE_IND;
    reg [7:0] rx_addr_b_q;
    reg [7:0] tx_addr_a_q;
    reg [7:0] tx_addr_b_q;
    reg [7:0] xfer_ctrl_q;
    reg [7:0] sub_addr_q;
    reg search_on_q;
    reg [5:0] found_addr_q;
    reg found_q;
    reg [7:0] rdata_q;
    reg cfi_m_q;
    reg cfi_s_q;
    reg pcm_m_q;
    reg pcm_s_q;
    reg [6:0] rx_sh_b_q;
    reg [7:0] rx_b_data_q;
    reg rx_b_stb_q;
    reg [6:0] mon_sh_q;
    reg [7:0] mon_tx_q;
    reg cfi_dout_q;
    reg cfi_oe_q;
    reg pcm_dout_q;
    reg pcm_oe_q;
    reg busy_q;
    reg cfi_bit_d;
    reg cfi_oe_d;
    reg pcm_bit_d;
    reg pcm_oe_d;
    reg [7:0] mon_byte_d;

    wire rise_tick;
    wire fall_tick;
    wire [6:0] slot;
    wire [2:0] bit_idx;
    wire [2:0] pos;
    wire [2:0] type_a;
    wire [2:0] type_b;
    wire [7:0] mask_a;
    wire [7:0] mask_b;
    wire en_a;
    wire en_b;
    wire hit_rx_b;
    wire hit_tx_a;
    wire hit_tx_b;
    wire rx_b_bit;
    wire mon_hit;
    wire mx_hit;
    wire mon_push_rx;
    wire mon_pop_tx;
    wire mon_push;
    wire [7:0] mon_push_data;
    wire mon_pop;
    wire [7:0] mon_head;
    wire sig_pop;
    wire [6:0] sig_head;
    wire rd_mon;
    wire rd_sig;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function [7:0] type_mask;
        input [2:0] t;
        begin
            case (t)
                3'h1: type_mask = 8'hff;
                3'h2: type_mask = 8'h0f;
                3'h3: type_mask = 8'hf0;
                3'h4: type_mask = 8'h03;
                3'h5: type_mask = 8'h0c;
                3'h6: type_mask = 8'h30;
                3'h7: type_mask = 8'hc0;
                default: type_mask = 8'h00;
            endcase
        end
    endfunction

    // Type 000 is not allowed, so such a channel never takes a slot.
    function chan_hit;
        input en;
        input [2:0] t;
        input [7:0] addr;
        input [6:0] s;
        begin
            chan_hit = en && (t != `SXM_TYPE_NONE) && (addr[6:0] == s);
        end
    endfunction

    // ------------------------------------------------------------
    // Frame timing and input synchronisers
    // ------------------------------------------------------------
    sxm_slot_timer u_timer (
        .sys_clk(sys_clk),
        .reset(reset),
        .link_clk(link_clk),
        .link_fsc(link_fsc),
        .rise_tick(rise_tick),
        .fall_tick(fall_tick),
        .slot(slot),
        .bit_idx(bit_idx)
    );

    always @(posedge sys_clk) begin
        if (reset) begin
            cfi_m_q <= 1'b1;
            cfi_s_q <= 1'b1;
            pcm_m_q <= 1'b1;
            pcm_s_q <= 1'b1;
        end else begin
            cfi_m_q <= cfi_din;
            cfi_s_q <= cfi_m_q;
            pcm_m_q <= pcm_din;
            pcm_s_q <= pcm_m_q;
        end
    end

    // Bit 7 is the first bit of a slot on both interfaces.
    assign pos = 3'h7 - bit_idx;

    // ------------------------------------------------------------
    // Channel decode
    // ------------------------------------------------------------
    assign en_a = xfer_ctrl_q[`SXM_BIT_EN_A];
    assign en_b = xfer_ctrl_q[`SXM_BIT_EN_B];
    assign type_a = xfer_ctrl_q[2:0];
    assign type_b = xfer_ctrl_q[5:3];
    assign mask_a = type_mask(type_a);
    assign mask_b = type_mask(type_b);
    assign hit_rx_b = chan_hit(en_b, type_b, rx_addr_b_q, slot);
    assign hit_tx_a = chan_hit(en_a, type_a, tx_addr_a_q, slot);
    assign hit_tx_b = chan_hit(en_b, type_b, tx_addr_b_q, slot);
    assign rx_b_bit = rx_addr_b_q[`SXM_BIT_IF_SEL] ? cfi_s_q : pcm_s_q;

    // Monitor channels sit on the even slot of the subscriber pair.
    assign mon_hit = (slot == {sub_addr_q[5:0], 1'b0});
    // The handshake bit is the last bit of the odd slot of a pair.
    assign mx_hit = search_on_q && rise_tick && slot[0]
        && (bit_idx == 3'h7) && !cfi_s_q;

    // ------------------------------------------------------------
    // Host port
    // ------------------------------------------------------------
    assign rd_mon = bus_rd && (bus_addr == `SXM_OFF_MON_FIFO);
    assign rd_sig = bus_rd && (bus_addr == `SXM_OFF_SIG_FIFO);

    always @(posedge sys_clk) begin
        if (reset) begin
            rx_addr_b_q <= `SXM_RST_ADDR;
            tx_addr_a_q <= `SXM_RST_ADDR;
            tx_addr_b_q <= `SXM_RST_ADDR;
            xfer_ctrl_q <= `SXM_RST_CTRL;
            sub_addr_q <= `SXM_RST_ADDR;
        end else if (bus_wr) begin
            case (bus_addr)
                `SXM_OFF_RX_ADDR_B: rx_addr_b_q <= bus_wdata;
                `SXM_OFF_TX_ADDR_A: tx_addr_a_q <= bus_wdata;
                `SXM_OFF_TX_ADDR_B: tx_addr_b_q <= bus_wdata;
                `SXM_OFF_XFER_CTRL: xfer_ctrl_q <= bus_wdata;
                `SXM_OFF_MON_ADDR: sub_addr_q <= bus_wdata;
                default: ;
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else if (bus_rd) begin
            case (bus_addr)
                `SXM_OFF_RX_ADDR_B: rdata_q <= rx_addr_b_q;
                `SXM_OFF_TX_ADDR_A: rdata_q <= tx_addr_a_q;
                `SXM_OFF_TX_ADDR_B: rdata_q <= tx_addr_b_q;
                `SXM_OFF_XFER_CTRL: rdata_q <= xfer_ctrl_q;
                `SXM_OFF_MON_ADDR: begin
                    rdata_q <= {1'b0, search_on_q, found_addr_q};
                end
                `SXM_OFF_MON_FIFO: begin
                    rdata_q <= mon_fifo_empty ? `SXM_EMPTY_READ : mon_head;
                end
                `SXM_OFF_SIG_FIFO: begin
                    rdata_q <= sig_fifo_empty ? `SXM_EMPTY_READ
                        : {1'b1, sig_head};
                end
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign bus_rdata = rdata_q;

    // ------------------------------------------------------------
    // Active channel search
    // ------------------------------------------------------------
    // A new search command outranks a find in the same cycle.
    always @(posedge sys_clk) begin
        if (reset) begin
            search_on_q <= ind_rst[`SXM_BIT_SEARCH_ON];
            found_addr_q <= ind_rst[5:0];
            found_q <= 1'b0;
        end else begin
            found_q <= 1'b0;
            if (search_cmd) begin
                search_on_q <= 1'b1;
            end else if (mx_hit) begin
                search_on_q <= 1'b0;
                found_addr_q <= slot[6:1];
                found_q <= 1'b1;
            end
        end
    end

    assign active_found = found_q;

    // ------------------------------------------------------------
    // Synchronous transfer, receive channel B
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (reset) begin
            rx_sh_b_q <= 7'h00;
            rx_b_data_q <= 8'h00;
            rx_b_stb_q <= 1'b0;
        end else begin
            rx_b_stb_q <= 1'b0;
            if (rise_tick && hit_rx_b) begin
                rx_sh_b_q <= {rx_sh_b_q[5:0], rx_b_bit};
                if (bit_idx == 3'h7) begin
                    // Bits outside the channel type read as zero.
                    rx_b_data_q <= {rx_sh_b_q, rx_b_bit} & mask_b;
                    rx_b_stb_q <= 1'b1;
                end
            end
        end
    end

    assign sync_rx_b_data = rx_b_data_q;
    assign sync_rx_b_stb = rx_b_stb_q;

    // ------------------------------------------------------------
    // Transmit bit selection
    // ------------------------------------------------------------
    // Channel A wins a collision with channel B; the monitor handler
    // drives only where no synchronous channel holds the bit.
    always @* begin
        cfi_bit_d = 1'b1;
        cfi_oe_d = 1'b0;
        pcm_bit_d = 1'b1;
        pcm_oe_d = 1'b0;
        mon_byte_d = (bit_idx == 3'h0) ?
            (mon_fifo_empty ? mon_tx_q : mon_head) : mon_tx_q;
        if (hit_tx_a && mask_a[pos]) begin
            if (tx_addr_a_q[`SXM_BIT_IF_SEL]) begin
                cfi_bit_d = sync_data_a[pos];
                cfi_oe_d = 1'b1;
            end else begin
                pcm_bit_d = sync_data_a[pos];
                pcm_oe_d = 1'b1;
            end
        end else if (hit_tx_b && mask_b[pos]) begin
            if (tx_addr_b_q[`SXM_BIT_IF_SEL]) begin
                cfi_bit_d = sync_data_b[pos];
                cfi_oe_d = 1'b1;
            end else begin
                pcm_bit_d = sync_data_b[pos];
                pcm_oe_d = 1'b1;
            end
        end
        if (mon_tx_en && mon_hit && !cfi_oe_d) begin
            cfi_bit_d = mon_byte_d[pos];
            cfi_oe_d = 1'b1;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            cfi_dout_q <= 1'b1;
            cfi_oe_q <= 1'b0;
            pcm_dout_q <= 1'b1;
            pcm_oe_q <= 1'b0;
            mon_tx_q <= 8'h00;
        end else if (fall_tick) begin
            cfi_dout_q <= cfi_bit_d;
            cfi_oe_q <= cfi_oe_d;
            pcm_dout_q <= pcm_bit_d;
            pcm_oe_q <= pcm_oe_d;
            // Past the message end the last byte repeats; its value
            // carries no meaning for either side.
            if (mon_tx_en && mon_hit && bit_idx == 3'h0)
                mon_tx_q <= mon_byte_d;
        end
    end

    assign cfi_dout = cfi_dout_q;
    assign cfi_dout_oe = cfi_oe_q;
    assign pcm_dout = pcm_dout_q;
    assign pcm_dout_oe = pcm_oe_q;

    // ------------------------------------------------------------
    // Memory access busy
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (reset)
            busy_q <= 1'b0;
        else if (rise_tick || fall_tick)
            busy_q <= hit_rx_b | hit_tx_a | hit_tx_b;
    end

    assign mem_access_busy = busy_q;

    // ------------------------------------------------------------
    // Monitor data buffer
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (reset)
            mon_sh_q <= 7'h00;
        else if (rise_tick && mon_rx_en && mon_hit)
            mon_sh_q <= {mon_sh_q[5:0], cfi_s_q};
    end

    assign mon_push_rx = rise_tick && mon_rx_en && mon_hit
        && (bit_idx == 3'h7);
    assign mon_pop_tx = fall_tick && mon_tx_en && mon_hit && !cfi_oe_q
        && !hit_tx_a && !hit_tx_b && (bit_idx == 3'h0);
    // A received byte takes the push port before a host write.
    assign mon_push = mon_push_rx
        || (bus_wr && bus_addr == `SXM_OFF_MON_FIFO);
    assign mon_push_data = mon_push_rx ? {mon_sh_q, cfi_s_q} : bus_wdata;
    assign mon_pop = mon_pop_tx || rd_mon;

    sxm_fifo #(
        .W(8),
        .DEPTH(`SXM_MON_DEPTH),
        .AW(`SXM_MON_AW)
    ) u_mon_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .clear(mon_fifo_reset),
        .push(mon_push),
        .push_data(mon_push_data),
        .pop(mon_pop),
        .head(mon_head),
        .empty(mon_fifo_empty),
        .full(mon_fifo_full)
    );

    assign mon_xfer_ctrl = sub_addr_q[7:6];

    // ------------------------------------------------------------
    // Signaling change queue
    // ------------------------------------------------------------
    // Entries are queued as given; an even address names a C/I change
    // and an odd one a SIG change. A change seen while full is dropped unless a read takes an entry in that cycle.
    assign sig_pop = rd_sig;

    sxm_fifo #(
        .W(7),
        .DEPTH(`SXM_SIG_DEPTH),
        .AW(`SXM_SIG_AW)
    ) u_sig_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .clear(sig_fifo_reset),
        .push(sig_change_stb),
        .push_data(sig_change_addr),
        .pop(sig_pop),
        .head(sig_head),
        .empty(sig_fifo_empty),
        .full()
    );
endmodule

/* tb/sxm_regs_sva.sv */
/* Port checker for the register group.
   Assumes it is bound onto sxm_regs and sees its ports only. */
`timescale 1ns/1ps
module sxm_regs_chk (
    input wire sys_clk,
    input wire reset,
    input wire [3:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    input wire [7:0] bus_rdata,
    input wire sync_rx_b_stb,
    input wire active_found,
    input wire mon_tx_en,
    input wire mon_fifo_empty,
    input wire mon_fifo_full,
    input wire [1:0] mon_xfer_ctrl,
    input wire sig_change_stb,
    input wire sig_fifo_empty
);
    // ----------------------------------------------------
    // Port relations
    // ----------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire rd_sig = bus_rd && bus_addr == 4'hc;
    wire rd_ind = bus_rd && bus_addr == 4'ha;
    sig_empty_rd_a: assert property (
        rd_sig && sig_fifo_empty |=> bus_rdata == 8'h00)
        else $error("empty queue read not zero");
    sig_valid_rd_a: assert property (
        rd_sig && !sig_fifo_empty |=> bus_rdata[7])
        else $error("queued entry not flagged valid");
    ind_top_a: assert property (
        rd_ind |=> !bus_rdata[7])
        else $error("indication top bit set");
    search_clear_a: assert property (
        active_found ##[1:4] rd_ind |=> !bus_rdata[6])
        else $error("search still on after find");
    sig_push_a: assert property (
        sig_change_stb |=> !sig_fifo_empty)
        else $error("change entry not queued");
    mon_push_a: assert property (
        bus_wr && bus_addr == 4'hb && !mon_tx_en |=> !mon_fifo_empty)
        else $error("monitor byte not stored");
    mon_flags_a: assert property (
        !(mon_fifo_full && mon_fifo_empty))
        else $error("buffer full and empty");
    sub_ctrl_a: assert property (
        bus_wr && bus_addr == 4'ha |=>
        mon_xfer_ctrl == {$past(bus_wdata[7]), $past(bus_wdata[6])})
        else $error("transfer control not loaded");
    rx_pulse_a: assert property (
        sync_rx_b_stb |=> !sync_rx_b_stb)
        else $error("receive strobe too long");
    found_pulse_a: assert property (
        active_found |=> !active_found)
        else $error("found pulse too long");
endmodule
bind sxm_regs sxm_regs_chk chk (.sys_clk(sys_clk), .reset(reset),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .sync_rx_b_stb(sync_rx_b_stb), .active_found(active_found),
    .mon_tx_en(mon_tx_en), .mon_fifo_empty(mon_fifo_empty),
    .mon_fifo_full(mon_fifo_full), .mon_xfer_ctrl(mon_xfer_ctrl),
    .sig_change_stb(sig_change_stb), .sig_fifo_empty(sig_fifo_empty));

/* tb/sxm_sub_model.sv */
/* Subscriber side of the serial link: clock, frame sync, data.
   Assumes the device drives its output after a falling edge. */
`timescale 1ns/1ps
module sxm_sub_model (
    output reg link_clk,
    output reg link_fsc,
    output reg cfi_din,
    output reg pcm_din,
    input wire cfi_dout
);
    // ----------------------------------------------------
    // Frame of 1024 bits, byte per slot, MSB first
    // ----------------------------------------------------
    reg [9:0] bit_q;
    reg [9:0] nb;
    reg [7:0] by;
    reg [7:0] shift;
    reg [7:0] cap [0:127];
    // Only slot 0x23 sends a low handshake bit, so a search
    // has exactly one channel to find.
    function [7:0] slot_byte(input [6:0] s);
        slot_byte = {s, s != 7'h23} ^ 8'h2c;
    endfunction
    initial begin
        link_clk = 1'b0;
        link_fsc = 1'b0;
        cfi_din = 1'b1;
        pcm_din = 1'b1;
        bit_q = 10'h3fe;
        #3;
        forever #40 link_clk = ~link_clk;
    end
    always @(negedge link_clk) begin
        nb = bit_q + 10'h1;
        by = slot_byte(nb[9:3]);
        bit_q <= nb;
        link_fsc <= nb == 10'h3ff;
        cfi_din <= by[~nb[2:0]];
        pcm_din <= by[~nb[2:0]];
    end
    always @(posedge link_clk) begin
        shift = {shift[6:0], cfi_dout};
        if (bit_q[2:0] == 3'h7) begin
            cap[bit_q[9:3]] <= shift;
        end
    end
endmodule

/* tb/test_sync_xfer_monitor_sig_regs.sv */
/* Self-checking bench for the register group.
   Assumes the subscriber model makes link clock and frames. */
`timescale 1ns/1ps
module test_sync_xfer_monitor_sig_regs;
    reg sys_clk, reset, bus_wr, bus_rd, search_cmd, mon_tx_en;
    reg sig_change_stb;
    reg [3:0] bus_addr;
    reg [7:0] bus_wdata, sync_data_a;
    reg [6:0] sig_change_addr;
    wire [7:0] bus_rdata, sync_rx_b_data;
    wire link_clk, link_fsc, cfi_din, pcm_din, cfi_dout;
    wire sync_rx_b_stb, active_found, mon_fifo_empty;
    wire mon_fifo_full, sig_fifo_empty, busy;
    wire [1:0] mon_xfer_ctrl;
    integer error_cnt, samples_checked, i, k;
    sxm_regs dut (.sys_clk(sys_clk), .reset(reset),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .link_clk(link_clk),
        .link_fsc(link_fsc), .cfi_din(cfi_din), .cfi_dout(cfi_dout),
        .cfi_dout_oe(), .pcm_din(pcm_din), .pcm_dout(),
        .pcm_dout_oe(), .sync_data_a(sync_data_a),
        .sync_data_b(8'h00), .sync_rx_b_data(sync_rx_b_data),
        .sync_rx_b_stb(sync_rx_b_stb), .mem_access_busy(busy),
        .search_cmd(search_cmd), .active_found(active_found),
        .mon_tx_en(mon_tx_en), .mon_rx_en(1'b0),
        .mon_fifo_reset(1'b0), .mon_fifo_empty(mon_fifo_empty),
        .mon_fifo_full(mon_fifo_full), .mon_xfer_ctrl(mon_xfer_ctrl),
        .sig_change_stb(sig_change_stb),
        .sig_change_addr(sig_change_addr), .sig_fifo_reset(1'b0),
        .sig_fifo_empty(sig_fifo_empty));
    sxm_sub_model sub (.link_clk(link_clk), .link_fsc(link_fsc),
        .cfi_din(cfi_din), .pcm_din(pcm_din), .cfi_dout(cfi_dout));
    // ----------------------------------------------------
    // Clock, tasks and verdict
    // ----------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    function [7:0] tmask(input [2:0] t);
        case (t)
            3'h1: tmask = 8'hff;
            3'h2: tmask = 8'h0f;
            3'h3: tmask = 8'hf0;
            default: tmask = 8'h03 << (2 * (t - 3'h4));
        endcase
    endfunction
    task check8(input string what, input [7:0] exp, input [7:0] got);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("wrong value %0s exp %h seen %h", what, exp, got);
            end
        end
    endtask
    task check1(input string what, input exp, input got);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("wrong value %0s exp %b seen %b", what, exp, got);
            end
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge sys_clk);
            bus_addr <= a;
            bus_wdata <= d;
            bus_wr <= 1'b1;
            @(posedge sys_clk);
            bus_wr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [7:0] exp);
        begin
            @(posedge sys_clk);
            bus_addr <= a;
            bus_rd <= 1'b1;
            @(posedge sys_clk);
            bus_rd <= 1'b0;
            #1;
            check8("read data", exp, bus_rdata);
        end
    endtask
    // Waits a bounded time for the strobe (0) or the find (1).
    task wait_on(input sel);
        begin
            k = 0;
            @(posedge sys_clk);
            #1;
            while ((sel ? active_found : sync_rx_b_stb) !== 1'b1
                   && k < 20000) begin
                @(posedge sys_clk);
                #1;
                k = k + 1;
            end
            check1("event seen", 1'b1, k < 20000);
        end
    endtask
    task end_of_test;
        begin
            $display("errors %0d checks %0d", error_cnt, samples_checked);
            if (error_cnt == 0 && samples_checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    initial begin
        #1000000;
        error_cnt = error_cnt + 1;
        end_of_test;
    end
    // ----------------------------------------------------
    // Tests
    // ----------------------------------------------------
    initial begin
        error_cnt = 0;
        samples_checked = 0;
        {reset, bus_wr, bus_rd, search_cmd, mon_tx_en} = 5'h10;
        {sig_change_stb, bus_addr, bus_wdata, sync_data_a} = 0;
        sig_change_addr = 7'h00;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        for (i = 6; i < 13; i = i + 1) rd(i[3:0], 8'h00);
        wr(4'h0, 8'hff);
        rd(4'h0, 8'h00);
        for (i = 6; i < 10; i = i + 1) begin
            wr(i[3:0], 8'h25 ^ i[7:0]);
            rd(i[3:0], 8'h25 ^ i[7:0]);
        end
        wr(4'ha, 8'h85);
        #1;
        check8("xfer ctrl", 8'h02, {6'h00, mon_xfer_ctrl});
        rd(4'ha, 8'h00);
        for (i = 0; i < 10; i = i + 1) begin
            @(posedge sys_clk);
            sig_change_stb <= 1'b1;
            sig_change_addr <= 7'h30 + i[6:0];
        end
        @(posedge sys_clk);
        sig_change_stb <= 1'b0;
        for (i = 0; i < 9; i = i + 1) rd(4'hc, {1'b1, 7'h30 + i[6:0]});
        rd(4'hc, 8'h00);
        for (i = 0; i < 17; i = i + 1) wr(4'hb, 8'h11 * i[7:0]);
        #1;
        check1("buffer full", 1'b1, mon_fifo_full);
        for (i = 0; i < 16; i = i + 1) rd(4'hb, 8'h11 * i[7:0]);
        check1("buffer empty", 1'b1, mon_fifo_empty);
        wr(4'hb, 8'hc3);
        wr(4'h7, 8'hd0);
        sync_data_a <= 8'h96;
        mon_tx_en <= 1'b1;
        for (i = 1; i < 8; i = i + 1) begin
            // Channel B runs each type 1 to 7 in slot 0x40; channel A stays on the full byte type.
            wr(4'h6, {i == 1, 7'h40});
            @(posedge link_fsc);
            wr(4'h9, {2'h3, i[2:0], 3'h1});
            wait_on(1'b0);
            check8("channel b", 8'had & tmask(i[2:0]), sync_rx_b_data);
            check1("busy flag", 1'b1, busy);
        end
        @(posedge link_fsc);
        check8("channel a", 8'h96, sub.cap[7'h50]);
        check8("monitor", 8'hc3, sub.cap[7'h0a]);
        check1("buffer empty", 1'b1, mon_fifo_empty);
        @(posedge sys_clk);
        search_cmd <= 1'b1;
        @(posedge sys_clk);
        search_cmd <= 1'b0;
        rd(4'ha, 8'h40);
        wait_on(1'b1);
        rd(4'ha, 8'h11);
        end_of_test;
    end
endmodule
